/* File: core/rmaf_formatter.sv */
// Management region formatter with AXI4-Lite registers and byte stream out
`default_nettype none
module rmaf_formatter
  import rmaf_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_nrst,
  input  wire logic [7:0]        i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [7:0]        i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  input  wire logic              i_out_ready,
  output rmaf_pkg::rmaf_byte_t   o_out,
  output rmaf_pkg::rmaf_cal_t    o_cal
);
  import rmaf_pkg::*;

  // Identity image: maker 32 B, serial 16 B, model 16 B (64 B); disc id 18 B reads back maker bytes 0..17
  logic [31:0]  id_mem_r [0:15];
  logic [1:0]   disc_st_r;
  logic [31:0]  pic0_r;
  logic [31:0]  pic1_r;
  logic [31:0]  wrs_r;
  logic [3:0]   slot_en_r;
  logic [23:0]  cal_addr_r;
  logic [12:0]  cal_idx_r;
  logic [12:0]  cal_left_r;
  logic         cal_full_r;

  rmaf_state_t  state_r;
  logic [3:0]   sec_r;
  logic [10:0]  pos_r;
  rmaf_byte_t   out_r;
  rmaf_cal_t    cal_r;

  logic         aw_got_r;
  logic         w_got_r;
  logic [7:0]   awaddr_r;
  logic [31:0]  wdata_r;
  logic [3:0]   wstrb_r;
  logic         bvalid_r;
  logic [1:0]   bresp_r;
  logic         rvalid_r;
  logic [31:0]  rdata_r;
  logic [1:0]   rresp_r;

  // Byte select from 32-bit words, little-endian within word
  function automatic logic [7:0] wbyte(input logic [31:0] w, input logic [1:0] b);
    wbyte = w[{b, 3'b000} +: 8];
  endfunction

  function automatic logic in_rng(input logic [10:0] p, input logic [10:0] lo,
                                  input logic [10:0] hi);
    in_rng = (p >= lo) && (p <= hi);
  endfunction

  // Identity bytes by unit position
  function automatic logic [7:0] id_byte(input logic [10:0] p);
    logic [10:0] rel;
    rel = 11'h000;
    if (in_rng(p, 11'h000, 11'h01F)) begin
      rel = p;
    end else if (in_rng(p, 11'h028, 11'h037)) begin
      rel = p - 11'h008;
    end else if (in_rng(p, 11'h040, 11'h04F)) begin
      rel = p - 11'h010;
    end else if (in_rng(p, 11'h058, 11'h069)) begin
      rel = p - 11'h018;
    end else begin
      rel = 11'h7FF;
    end
    id_byte = (rel == 11'h7FF) ? 8'h00 : wbyte(id_mem_r[rel[5:2]], rel[1:0]);
  endfunction

  // Write channel
  wire        wr_fire    = aw_got_r && w_got_r && !bvalid_r;
  wire        id_hit     = (awaddr_r >= REG_ID_BASE) && (awaddr_r <= REG_ID_LAST);
  wire [3:0]  id_widx    = 4'((awaddr_r - REG_ID_BASE) >> 2);
  wire        busy       = (state_r != RMAF_IDLE);
  wire        wr_ctrl    = wr_fire && (awaddr_r == REG_CTRL);
  wire        wr_known;
  assign wr_known = (awaddr_r == REG_CTRL) || (awaddr_r == REG_DISC_ST) ||
                    (awaddr_r == REG_PIC0) || (awaddr_r == REG_PIC1) ||
                    (awaddr_r == REG_WRS) || (awaddr_r == REG_SLOT_EN) || id_hit;
  wire [1:0]  cmd        = wr_ctrl ? wdata_r[1:0] : CMD_NONE;
  wire        st_ok      = (wdata_r[7:2] == 6'h00) && (wdata_r[1:0] <= ST_LAST);

  // Calibration grant: one sector per request, outer end first
  wire        cal_req    = (cmd == CMD_CAL) && !cal_full_r;
  wire [23:0] cal_blk    = CAL_FIRST_BLK + 24'(cal_idx_r >> SEC_PER_BLK_SH);

  // Stream bytes
  wire        beat       = !out_r.valid || i_out_ready;
  wire [10:0] p          = pos_r;
  logic [7:0] lead_byte;
  logic [7:0] rec_byte;
  logic [7:0] f0_byte;
  logic [7:0] f1_byte;
  wire [6:0]  sp         = p[6:0];
  wire [1:0]  slot       = p[8:7];
  wire        slot_on    = slot_en_r[slot] && (p < SLOTS_END);

  // Lead-in: sectors 0..7 reserved zero, 8..15 identity units
  assign lead_byte = (sec_r <= {1'b0, RSV_UNITS}) ? 8'h00 : id_byte(p);

  always_comb begin
    f0_byte = 8'h00;
    if (p == 11'h000) begin
      f0_byte = FMT_HI;
    end else if (p == 11'h001) begin
      f0_byte = FMT_LO;
    end else if (p == 11'h002) begin
      f0_byte = {6'h00, disc_st_r};
    end else if (in_rng(p, 11'h004, 11'h015)) begin
      f0_byte = id_byte(p + 11'h054);
    end else if (p == 11'h016) begin
      f0_byte = TAG1;
    end else if (in_rng(p, 11'h017, 11'h01A)) begin
      f0_byte = wbyte(pic0_r, 2'(p - 11'h017));
    end else if (p == 11'h01B) begin
      f0_byte = wbyte(pic1_r, 2'h2);
    end else if (p == 11'h01E) begin
      f0_byte = TAG2;
    end else if (in_rng(p, 11'h01F, 11'h020)) begin
      f0_byte = wbyte(pic1_r, 2'(p - 11'h01F));
    end else if (in_rng(p, 11'h021, 11'h024)) begin
      f0_byte = wbyte(wrs_r, 2'(p - 11'h021));
    end else if (p == 11'h026) begin
      f0_byte = TAG3;
    end else if (p == 11'h02E) begin
      f0_byte = TAG4;
    end else if (p == 11'h036) begin
      f0_byte = TAG5;
    end else if (in_rng(p, 11'h027, 11'h02C)) begin
      f0_byte = id_byte(p - 11'h027 + 11'h058);
    end else if (in_rng(p, 11'h02F, 11'h034)) begin
      f0_byte = id_byte(p - 11'h02F + 11'h05E);
    end else if (in_rng(p, 11'h037, 11'h03C)) begin
      f0_byte = id_byte(p - 11'h037 + 11'h064);
    end
  end

  // Field 1: calibration address big-endian at slot bytes 80..83
  always_comb begin
    f1_byte = 8'h00;
    if (slot_on && (sp >= SLOT_CAL_ADDR[6:0]) && (sp < SLOT_CAL_ADDR[6:0] + 7'h04)) begin
      case (sp[1:0])
        2'h0: f1_byte = 8'h00;
        2'h1: f1_byte = cal_addr_r[23:16];
        2'h2: f1_byte = cal_addr_r[15:8];
        default: f1_byte = cal_addr_r[7:0];
      endcase
    end
  end

  // Sector 0 linking loss, 1 field 0, 2 field 1, rest zero here
  assign rec_byte = (sec_r == 4'h1) ? f0_byte :
                    (sec_r == 4'h2) ? f1_byte : 8'h00;

  wire end_pos = (pos_r == UNIT_LAST);
  wire end_sec = (sec_r == SEC_LAST);

  // Stream state
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= RMAF_IDLE;
      sec_r   <= 4'h0;
      pos_r   <= 11'h000;
      out_r   <= '0;
    end else if (beat) begin
      out_r.valid <= busy;
      out_r.data  <= (state_r == RMAF_LEAD) ? lead_byte : rec_byte;
      out_r.first <= busy && (pos_r == 11'h000);
      out_r.last  <= busy && end_pos;
      out_r.sector <= sec_r;
      if (!busy) begin
        if (cmd == CMD_LEAD) begin
          state_r <= RMAF_LEAD;
        end else if (cmd == CMD_REC) begin
          state_r <= RMAF_REC;
        end
      end else begin
        pos_r <= pos_r + 11'h001;
        if (end_pos) begin
          sec_r <= sec_r + 4'h1;
          if (end_sec) begin
            state_r <= RMAF_IDLE;
          end
        end
      end
    end
  end

  // Calibration allocator and configuration
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cal_idx_r  <= CAL_SEC_LAST;
      cal_left_r <= CAL_SECTORS;
      cal_full_r <= 1'b0;
      cal_addr_r <= CAL_LAST_BLK;
      cal_r      <= '0;
      disc_st_r  <= 2'h0;
      pic0_r     <= 32'h0;
      pic1_r     <= 32'h0;
      wrs_r      <= 32'h0;
      slot_en_r  <= 4'h1;
    end else begin
      cal_r.valid <= cal_req;
      if (cal_req) begin
        cal_r.blk    <= cal_blk;
        cal_r.sector <= cal_idx_r;
        cal_addr_r   <= cal_blk;
        cal_left_r   <= cal_left_r - 13'h1;
        cal_full_r   <= (cal_idx_r == 13'h0);
        cal_idx_r    <= (cal_idx_r == 13'h0) ? 13'h0 : cal_idx_r - 13'h1;
      end
      if (wr_fire && !busy) begin
        if (awaddr_r == REG_DISC_ST && st_ok) begin
          disc_st_r <= wdata_r[1:0];
        end else if (awaddr_r == REG_PIC0) begin
          pic0_r <= wdata_r;
        end else if (awaddr_r == REG_PIC1) begin
          pic1_r <= wdata_r;
        end else if (awaddr_r == REG_WRS) begin
          wrs_r <= wdata_r;
        end else if (awaddr_r == REG_SLOT_EN) begin
          slot_en_r <= wdata_r[3:0];
        end
      end
    end
  end

  // Identity image, frozen while streaming
  always_ff @(posedge i_sys_clk) begin
    if (wr_fire && !busy && id_hit) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_r[b]) begin
          id_mem_r[id_widx][b*8 +: 8] <= wdata_r[b*8 +: 8];
        end
      end
    end
  end

  // AXI4-Lite write
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0;
      wstrb_r  <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OK;
    end else begin
      if (i_awvalid && !aw_got_r) begin
        aw_got_r <= 1'b1;
        awaddr_r <= {i_awaddr[7:2], 2'b00};
      end
      if (i_wvalid && !w_got_r) begin
        w_got_r <= 1'b1;
        wdata_r <= i_wdata;
        wstrb_r <= i_wstrb;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= (wr_known && !(busy && !wr_ctrl) &&
                     !(awaddr_r == REG_DISC_ST && !st_ok)) ? RESP_OK : RESP_SLVERR;
      end else if (bvalid_r && i_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // AXI4-Lite read
  logic [31:0] rd_val;
  logic        rd_ok;
  wire [7:0]   ra = {i_araddr[7:2], 2'b00};
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0;
    if (ra == REG_CTRL) begin
      // Management region span, first block low half
      rd_val = {MGT_LAST_BLK[15:0], MGT_FIRST_BLK[15:0]};
    end else if (ra == REG_STATUS) begin
      rd_val = {24'h0, sec_r, 1'b0, cal_full_r, state_r};
    end else if (ra == REG_DISC_ST) begin
      rd_val = {30'h0, disc_st_r};
    end else if (ra == REG_CAL_ADDR) begin
      rd_val = {8'h00, cal_addr_r};
    end else if (ra == REG_CAL_NEXT) begin
      rd_val = {19'h0, cal_idx_r};
    end else if (ra == REG_CAL_LEFT) begin
      rd_val = {19'h0, cal_left_r};
    end else if (ra == REG_PIC0) begin
      rd_val = pic0_r;
    end else if (ra == REG_PIC1) begin
      rd_val = pic1_r;
    end else if (ra == REG_WRS) begin
      rd_val = wrs_r;
    end else if (ra == REG_SLOT_EN) begin
      rd_val = {28'h0, slot_en_r};
    end else if ((ra >= REG_ID_BASE) && (ra <= REG_ID_LAST)) begin
      rd_val = id_mem_r[4'((ra - REG_ID_BASE) >> 2)];
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= RESP_OK;
    end else if (!rvalid_r && i_arvalid) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_val;
      rresp_r  <= rd_ok ? RESP_OK : RESP_SLVERR;
    end else if (rvalid_r && i_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Ready pulses registered on the same edge as capture
  logic awready_r;
  logic wready_r;
  logic arready_r;
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      arready_r <= 1'b0;
    end else begin
      awready_r <= i_awvalid && !aw_got_r && !awready_r;
      wready_r  <= i_wvalid && !w_got_r && !wready_r;
      arready_r <= !rvalid_r && i_arvalid;
    end
  end

  assign o_awready = awready_r;
  assign o_wready  = wready_r;
  assign o_bvalid  = bvalid_r;
  assign o_bresp   = bresp_r;
  assign o_arready = arready_r;
  assign o_rvalid  = rvalid_r;
  assign o_rdata   = rdata_r;
  assign o_rresp   = rresp_r;
  assign o_out     = out_r;
  assign o_cal     = cal_r;
endmodule
`default_nettype wire

/* File: core/rmaf_pkg.sv */
// Package for the management region formatter: map, layouts, constants
`default_nettype none
package rmaf_pkg;
  // Register byte offsets, identity word count and last identity word index
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_DISC_ST   = 8'h08;
  localparam logic [7:0] REG_CAL_ADDR  = 8'h0C;
  localparam logic [7:0] REG_CAL_NEXT  = 8'h10;
  localparam logic [7:0] REG_CAL_LEFT  = 8'h14;
  localparam logic [7:0] REG_PIC0      = 8'h18;
  localparam logic [7:0] REG_PIC1      = 8'h1C;
  localparam logic [7:0] REG_WRS       = 8'h20;
  localparam logic [7:0] REG_SLOT_EN   = 8'h24;
  localparam logic [7:0] REG_ID_BASE   = 8'h40;
  localparam logic [7:0] REG_ID_LAST   = 8'h7C;
  localparam logic [7:0] REG_ID_WORDS  = 8'h10;
  localparam logic [3:0] ID_IDX_W_LAST = 4'hF;

  // Address ranges in error-correction blocks, calibration sector counts and sectors-per-block shift
  localparam logic [23:0] CAL_FIRST_BLK = 24'h002080;
  localparam logic [23:0] CAL_LAST_BLK  = 24'h00223A;
  localparam logic [23:0] MGT_FIRST_BLK = 24'h00223C;
  localparam logic [23:0] MGT_LAST_BLK  = 24'h0024F8;
  localparam logic [12:0] CAL_SECTORS   = 13'h1BB0;
  localparam logic [12:0] CAL_SEC_LAST  = 13'h1BAF;
  localparam logic [4:0]  SEC_PER_BLK_SH = 5'h04;

  // Frame layout
  localparam logic [10:0] UNIT_LAST  = 11'h7FF;
  localparam logic [3:0]  SEC_LAST   = 4'hF;
  localparam logic [2:0]  RSV_UNITS  = 3'h7;
  localparam logic [7:0]  FMT_HI     = 8'h00;
  localparam logic [7:0]  FMT_LO     = 8'h01;
  localparam logic [1:0]  ST_LAST    = 2'h3;
  localparam logic [7:0]  TAG1 = 8'h01;
  localparam logic [7:0]  TAG2 = 8'h02;
  localparam logic [7:0]  TAG3 = 8'h03;
  localparam logic [7:0]  TAG4 = 8'h04;
  localparam logic [7:0]  TAG5 = 8'h05;
  localparam logic [10:0] SLOT_CAL_ADDR = 11'h050;
  localparam logic [10:0] SLOT_RUN_END  = 11'h06C;
  localparam logic [10:0] SLOTS_END     = 11'h200;

  // Frame kinds and command codes
  localparam logic [1:0] CMD_NONE  = 2'h0;
  localparam logic [1:0] CMD_LEAD  = 2'h1;
  localparam logic [1:0] CMD_REC   = 2'h2;
  localparam logic [1:0] CMD_CAL   = 2'h3;
  localparam logic [1:0] RESP_OK     = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    RMAF_IDLE = 2'b00,
    RMAF_LEAD = 2'b01,
    RMAF_REC  = 2'b11
  } rmaf_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       first;
    logic       last;
    logic [3:0] sector;
  } rmaf_byte_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] blk;
    logic [12:0] sector;
  } rmaf_cal_t;
endpackage
`default_nettype wire

/* File: tb/rmaf_formatter_asserts.sv */
// Concurrent checks on the formatter byte stream and calibration grants
`default_nettype none
module rmaf_formatter_asserts
  import rmaf_pkg::*;
(
  input wire logic                 i_sys_clk,
  input wire logic                 i_nrst,
  input wire logic                 i_out_ready,
  input wire rmaf_pkg::rmaf_byte_t o_out,
  input wire rmaf_pkg::rmaf_cal_t  o_cal
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] pos_r;
  logic [3:0]  sec_r;
  logic [12:0] cal_r;
  logic        seen_r;

  // Expected byte position, sector and last granted index
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pos_r <= 11'h000;
      sec_r <= 4'h0;
      cal_r <= 13'h0000;
      seen_r <= 1'b0;
    end else begin
      if (o_out.valid && i_out_ready) begin
        pos_r <= pos_r + 11'h001;
        if (o_out.last) sec_r <= o_out.sector + 4'h1;
      end
      if (o_cal.valid) begin
        cal_r <= o_cal.sector;
        seen_r <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_take;  o_out.valid && i_out_ready;  endsequence
  sequence s_stall; o_out.valid && !i_out_ready; endsequence
  sequence s_grant; o_cal.valid;                 endsequence

  chk_byte_hold: assert property (s_stall |=> o_out.valid && $stable(o_out))
    else $error("stalled byte changed");
  chk_first_pos: assert property (s_take |-> o_out.first == (pos_r == 11'h000))
    else $error("first marker off position zero");
  chk_last_pos: assert property (s_take |-> o_out.last == (pos_r == UNIT_LAST))
    else $error("last marker off final position");
  chk_sector_step: assert property (s_take ##0 o_out.first |-> o_out.sector == sec_r)
    else $error("sector out of order");
  chk_frame_end: assert property (s_take ##0 (o_out.last && o_out.sector == SEC_LAST)
    |=> !o_out.valid)
    else $error("stream ran past sixteen sectors");
  chk_cal_range: assert property (s_grant |-> o_cal.blk >= CAL_FIRST_BLK
    && o_cal.blk <= CAL_LAST_BLK)
    else $error("grant outside calibration region");
  chk_cal_block: assert property (s_grant |->
    o_cal.blk == CAL_FIRST_BLK + 24'(o_cal.sector >> SEC_PER_BLK_SH))
    else $error("grant block does not match sector");
  chk_cal_index: assert property (s_grant |-> o_cal.sector <= CAL_SEC_LAST)
    else $error("grant index beyond region");
  chk_cal_order: assert property (s_grant ##0 seen_r |->
    o_cal.sector == cal_r - 13'h0001)
    else $error("grant not next sector inward");
  chk_cal_single: assert property (s_grant |=> !o_cal.valid)
    else $error("grant pulse longer than one sector");
endmodule

bind rmaf_formatter rmaf_formatter_asserts u_chk (
  .i_sys_clk   (i_sys_clk),
  .i_nrst      (i_nrst),
  .i_out_ready (i_out_ready),
  .o_out       (o_out),
  .o_cal       (o_cal)
);
`default_nettype wire

/* File: tb/rmaf_sink.sv */
// Recording channel model: takes stream bytes with random stalls
`default_nettype none
module rmaf_sink (
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  output logic      o_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bytes taken as they come, identity contents never inspected
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ready <= 1'b0;
    end else begin
      o_ready <= ($urandom_range(15) != 0);
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Bench: register access, lead-in, calibration grants and record stream
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rmaf_pkg::*;
  logic        i_sys_clk, i_nrst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic        i_out_ready, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [7:0]  i_awaddr, i_araddr, disc_st;
  logic [31:0] i_wdata, o_rdata, pic0, pic1, wrs, rd;
  logic [3:0]  i_wstrb;
  logic [1:0]  o_bresp, o_rresp;
  rmaf_byte_t  o_out;
  rmaf_cal_t   o_cal;
  int          miscompares, samples_checked;
  rmaf_byte_t  exp_q[$];
  rmaf_cal_t   cal_q[$];
  logic [7:0]  id_b[64];
  logic [23:0] cal_blk;
  logic [12:0] cal_sec;

  rmaf_formatter DUT (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .i_out_ready(i_out_ready), .o_out(o_out), .o_cal(o_cal)
  );
  rmaf_sink u_sink (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .o_ready(i_out_ready));

  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      miscompares++;
      $display("mismatch timeout expected answer seen none");
      results();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw_seen;
    logic w_seen;
    n = 0;
    aw_seen = 1'b0;
    w_seen = 1'b0;
    @(posedge i_sys_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      n++;
      if (o_awready) begin
        i_awvalid <= 1'b0;
        aw_seen = 1'b1;
      end
      if (o_wready) begin
        i_wvalid <= 1'b0;
        w_seen = 1'b1;
      end
    end while (!o_bvalid && n < 50);
    guard(n, 50);
    i_bready <= 1'b0;
    check("write response", 40'(o_bresp), 40'(er));
    check("write address taken", 40'(aw_seen), 40'h1);
    check("write data taken", 40'(w_seen), 40'h1);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic ar_seen;
    n = 0;
    ar_seen = 1'b0;
    @(posedge i_sys_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      n++;
      if (o_arready) begin
        i_arvalid <= 1'b0;
        ar_seen = 1'b1;
      end
    end while (!o_rvalid && n < 50);
    guard(n, 50);
    i_rready <= 1'b0;
    check("read response", 40'(o_rresp), 40'(er));
    check("read address taken", 40'(ar_seen), 40'h1);
    if (er == RESP_OK) check("read data", 40'(o_rdata), 40'(ed));
  endtask

  // Bit 8 set where the byte value is fixed, clear for free-format bytes
  function automatic logic [8:0] exp_byte(input logic [1:0] k, input int s, input int p);
    logic [8:0] z;
    z = 9'h100;
    if (k == CMD_LEAD && s >= 8) begin
      case (p) inside
        [0:31]:   z = {1'b1, id_b[p]};
        [40:55]:  z = {1'b1, id_b[p-8]};
        [64:79]:  z = {1'b1, id_b[p-16]};
        [88:105]: z = 9'h000;
        default:  ;
      endcase
    end else if (k == CMD_REC && s == 1) begin
      case (p) inside
        0:        z = {1'b1, FMT_HI};
        1:        z = {1'b1, FMT_LO};
        2:        z = {1'b1, disc_st};
        22:       z = {1'b1, TAG1};
        [23:26]:  z = {1'b1, pic0[8*(p-23) +: 8]};
        27:       z = {1'b1, pic1[23:16]};
        30:       z = {1'b1, TAG2};
        [31:32]:  z = {1'b1, pic1[8*(p-31) +: 8]};
        [33:36]:  z = {1'b1, wrs[8*(p-33) +: 8]};
        38:       z = {1'b1, TAG3};
        46:       z = {1'b1, TAG4};
        54:       z = {1'b1, TAG5};
        [4:21], [39:44], [47:52], [55:60]: z = 9'h000;
        default:  ;
      endcase
    end else if (k == CMD_REC && s == 2) begin
      case (p) inside
        [81:83]:          z = {1'b1, cal_blk[8*(83-p) +: 8]};
        [0:79], [84:107]: z = 9'h000;
        default:          ;
      endcase
    end
    return z;
  endfunction

  task automatic push_frame(input logic [1:0] k);
    logic [8:0] b;
    for (int s = 0; s < 16; s++) begin
      for (int p = 0; p < 2048; p++) begin
        b = exp_byte(k, s, p);
        exp_q.push_back({b[8], b[7:0], p == 0, p == 2047, 4'(s)});
      end
    end
  endtask

  task automatic drain();
    int n;
    n = 0;
    while ((exp_q.size() != 0 || o_out.valid) && n < 45000) begin
      @(posedge i_sys_clk);
      n++;
    end
    guard(n, 45000);
  endtask

  // Output watcher: compares each taken byte and grant with the oldest note
  always @(posedge i_sys_clk) begin
    rmaf_byte_t e;
    if (i_nrst && o_out.valid && i_out_ready) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 15'h7FFF;
      check("byte markers", 40'(o_out[5:0]), 40'(e[5:0]));
      if (e.valid) check("byte data", 40'(o_out.data), 40'(e.data));
    end
    if (i_nrst && o_cal.valid) begin
      check("grant", 40'(o_cal), 40'((cal_q.size() != 0) ? cal_q.pop_front() : '0));
    end
  end

  initial begin
    i_nrst = 1'b0;
    i_awaddr = 8'h00;
    i_araddr = 8'h00;
    i_wdata = 32'h00000000;
    i_wstrb = 4'hF;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    void'($urandom(32'h44912cba));
    repeat (6) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    axi_rd(REG_CAL_ADDR, 32'(CAL_LAST_BLK), RESP_OK);
    axi_rd(REG_CAL_NEXT, 32'(CAL_SEC_LAST), RESP_OK);
    axi_rd(REG_CAL_LEFT, 32'(CAL_SECTORS), RESP_OK);
    axi_rd(REG_SLOT_EN, 32'h00000001, RESP_OK);
    axi_rd(REG_CTRL, {MGT_LAST_BLK[15:0], MGT_FIRST_BLK[15:0]}, RESP_OK);
    axi_rd(8'h30, 32'h00000000, RESP_SLVERR);
    $display("test reset values done");
    for (int st = 0; st < 4; st++) begin
      axi_wr(REG_DISC_ST, 32'(st), RESP_OK);
      axi_rd(REG_DISC_ST, 32'(st), RESP_OK);
    end
    axi_wr(REG_DISC_ST, 32'h00000004, RESP_SLVERR);
    axi_rd(REG_DISC_ST, 32'h00000003, RESP_OK);
    $display("test disc status done");
    for (int k = 0; k < 16; k++) begin
      rd = $urandom();
      {id_b[4*k+3], id_b[4*k+2], id_b[4*k+1], id_b[4*k]} = rd;
      axi_wr(REG_ID_BASE + 8'(4*k), rd, RESP_OK);
    end
    push_frame(CMD_LEAD);
    axi_wr(REG_CTRL, 32'(CMD_LEAD), RESP_OK);
    axi_wr(REG_DISC_ST, 32'h00000002, RESP_SLVERR);
    drain();
    axi_rd(REG_DISC_ST, 32'h00000003, RESP_OK);
    $display("test lead-in done");
    for (int g = 0; g < 3; g++) begin
      cal_sec = CAL_SEC_LAST - 13'(g);
      cal_blk = CAL_FIRST_BLK + 24'(cal_sec >> 4);
      cal_q.push_back({1'b1, cal_blk, cal_sec});
      axi_wr(REG_CTRL, 32'(CMD_CAL), RESP_OK);
    end
    axi_rd(REG_CAL_LEFT, 32'(CAL_SECTORS) - 32'h00000003, RESP_OK);
    axi_rd(REG_CAL_ADDR, 32'(cal_blk), RESP_OK);
    check("grants left", 40'(cal_q.size()), 40'h0);
    $display("test calibration done");
    pic0 = $urandom();
    pic1 = $urandom();
    wrs = $urandom();
    disc_st = 8'h02;
    axi_wr(REG_PIC0, pic0, RESP_OK);
    axi_wr(REG_PIC1, pic1, RESP_OK);
    axi_wr(REG_WRS, wrs, RESP_OK);
    axi_wr(REG_DISC_ST, 32'(disc_st), RESP_OK);
    push_frame(CMD_REC);
    axi_wr(REG_CTRL, 32'(CMD_REC), RESP_OK);
    drain();
    $display("test record done");
    results();
  end
endmodule
`default_nettype wire
